// ### design/diag_device.sv
// Functional notes
// [RL1] board code latched once at start-up
// [RL2] board code byte in diagnosis answer
// [RL3] resistor ranges map ascending to codes
// [RL4] fault monitoring active also in fallback
// [RL5] open threshold selectable, low default
// [RL6] open fault closes bypass, sets flag
// [RL7] write bit 1 clears open faults
// [RL8] short blanking 16 or 32 us
// [RL9] short only flags; host bypasses
// [RL10] write bit 0 clears short faults
// [RL11] two heat warnings in code register
// [RL12] no autonomous action on overheating
// [RL13] temperature sampled only on command
// [RL14] undervoltage opens switches, refuses link
// [RL15] status register direct or broadcast
// [RL16] reset indicator zero after power-on
// [RL17] illegal command flag, write-one clear
// [RL18] third wrong key locks nonvolatile memory
// [RL19] bad register flag, communication continues
// [RL20] restricted access flag, write-one clear
// [RL21] nonvolatile success flag, write-one clear
// [RL22] clear bits read zero, restart channels
// [RL23] fault registers readable, command clears
// [RL24] all flags sticky until cleared; heat warnings follow each measurement, health and fallback bits are live
`timescale 1ns/100ps
`default_nettype none
module diag_device (
	input wire logic clk_sys,
	input wire logic resetn,
	diag_link_if.device link,
	input wire logic [diag_pkg::CODE_W-1:0] board_code_adc,
	input wire logic board_resistor_fault_in,
	input wire logic [diag_pkg::CHANNELS-1:0] open_cmp,
	input wire logic [diag_pkg::CHANNELS-1:0] short_cmp,
	input wire logic [diag_pkg::CHANNELS-1:0] switch_high_ohmic,
	input wire logic heat_low_cmp,
	input wire logic heat_high_cmp,
	input wire logic chip_health_in,
	input wire logic fallback_mode_in,
	input wire logic undervoltage,
	input wire logic long_blank_sel,
	input wire logic open_thresh_high_sel,
	output logic open_thresh_high,
	output logic [diag_pkg::CHANNELS-1:0] bypass_close,
	output logic all_switches_open,
	output logic temp_measure_start
);
	import diag_pkg::*;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	localparam int SYW = 3 * CHANNELS + 7;
	logic [SYW-1:0] sync1_r; // first stage, read only by sync2_r
	logic [SYW-1:0] sync2_r; // usable copy
	logic [CODE_W:0] code_sync1_r, code_sync2_r; // board code pins, never reset
	logic [CHANNELS-1:0] open_s, short_s, hi_s;
	logic [CHANNELS-1:0] hi_d_r; // switch state one cycle back, for the turn-on edge
	logic heat_lo_s, heat_hi_s, health_s, fallback_s, uv_s, long_s, thr_s;
	// two flops on every pin that comes from the analog side
	always_ff @(posedge clk_sys) begin
		// code pins run through reset so the capture right after it sees settled values
		code_sync1_r <= {board_code_adc, board_resistor_fault_in};
		code_sync2_r <= code_sync1_r;
		if (!resetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
			hi_d_r <= '0;
		end else begin
			sync1_r <= {open_cmp, short_cmp, switch_high_ohmic, heat_low_cmp, heat_high_cmp, chip_health_in,
				fallback_mode_in, undervoltage, long_blank_sel, open_thresh_high_sel};
			sync2_r <= sync1_r;
			hi_d_r <= hi_s;
		end
	end
	assign {open_s, short_s, hi_s, heat_lo_s, heat_hi_s, health_s, fallback_s, uv_s, long_s, thr_s} = sync2_r;

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	logic take; // frame accepted this cycle
	logic wr_status; // write to the status register
	logic rd; // read request
	logic known_addr; // address exists for reads
	logic clear_open, clear_short; // clear strobes
	logic [7:0] wd; // write data
	// known readable address
	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == STATUS_AND_CLEAR_ADDR) || (a == BOARD_CODE_ADDR) || (a >= OPEN_FAULT_LO_ADDR && a <= SHORT_FAULT_HI_ADDR);
	endfunction : addr_known
	// [RL14] refuse during undervoltage
	assign take = link.req_valid && !uv_s;
	assign wd = link.req_wdata;
	assign rd = take && link.req_kind == REQ_READ;
	assign known_addr = addr_known(link.req_addr);
	// [RL15] status write taken direct or broadcast
	assign wr_status = take && link.req_kind == REQ_WRITE && link.req_addr == STATUS_AND_CLEAR_ADDR;
	// [RL23] command code clears both fault kinds
	assign clear_open = (wr_status && wd[BIT_CLEAR_OPEN]) || (take && link.req_kind == REQ_CMD && link.req_cmd == CMD_CLEAR_FAULTS);
	assign clear_short = (wr_status && wd[BIT_CLEAR_SHORT]) || (take && link.req_kind == REQ_CMD && link.req_cmd == CMD_CLEAR_FAULTS);
	assign link.link_ready = !uv_s;
	// ----------------------------------------
	// start-up board code capture
	// ----------------------------------------
	logic code_taken_r; // capture done flag
	logic [CODE_W-1:0] code_r; // latched code
	logic code_fault_r; // latched resistor fault
	// [RL1] one capture after release of reset
	// [RL3] adc code is binary ascending range
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			code_taken_r <= 1'b0;
			code_r <= '0;
			code_fault_r <= 1'b0;
		end else if (!code_taken_r) begin
			code_taken_r <= 1'b1;
			code_r <= code_sync2_r[CODE_W:1];
			code_fault_r <= code_sync2_r[0];
		end
	end
	// ----------------------------------------
	// per-channel fault detection
	// ----------------------------------------
	logic [CHANNELS-1:0] open_fault_r, short_fault_r;
	logic [CHANNELS-1:0] blank_done;
	logic [BLANK_W-1:0] blank_len;
	assign blank_len = long_s ? BLANK_W'(BLANK_LONG_CYC) : BLANK_W'(BLANK_SHORT_CYC);

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
			logic [BLANK_W-1:0] blank_r; // blanking countdown
			// [RL8] blanking restarts on each turn to high ohmic
			always_ff @(posedge clk_sys) begin
				if (!resetn) begin
					blank_r <= '0;
				end else if (hi_s[ch] && !hi_d_r[ch]) begin
					blank_r <= blank_len;
				end else if (!hi_s[ch]) begin
					blank_r <= '0;
				end else if (blank_r != '0) begin
					blank_r <= blank_r - BLANK_W'(1);
				end
			end
			assign blank_done[ch] = hi_s[ch] && blank_r == '0 && hi_d_r[ch];
			// [RL6] open seen as soon as high ohmic
			// [RL4] no fallback gating
			// [RL24] sticky, set wins over clear
			always_ff @(posedge clk_sys) begin
				if (!resetn) begin
					open_fault_r[ch] <= 1'b0;
				end else if (open_s[ch] && hi_s[ch]) begin
					open_fault_r[ch] <= 1'b1;
				end else if (clear_open) begin
					// [RL7] clear lets channel resume
					open_fault_r[ch] <= 1'b0;
				end
			end
			// [RL9] short only flags the channel
			// [RL10] after clear, recheck sets again
			always_ff @(posedge clk_sys) begin
				if (!resetn) begin
					short_fault_r[ch] <= 1'b0;
				end else if (short_s[ch] && blank_done[ch]) begin
					short_fault_r[ch] <= 1'b1;
				end else if (clear_short) begin
					short_fault_r[ch] <= 1'b0;
				end
			end
		end
	endgenerate
	// [RL6] close bypass on open fault
	// [RL14] all switches open on undervoltage
	assign bypass_close = uv_s ? '0 : open_fault_r;
	assign all_switches_open = uv_s;
	// [RL5] low threshold unless selected high
	assign open_thresh_high = thr_s;
	// ----------------------------------------
	// temperature warnings
	// ----------------------------------------
	logic heat_low_r, heat_high_r, temp_go;
	// [RL13] sample only on command 13 or 46
	assign temp_go = take && link.req_kind == REQ_CMD &&
		((link.req_cmd == CMD_TEMP_ONE && !link.req_bcast) || (link.req_cmd == CMD_TEMP_ALL && link.req_bcast));
	assign temp_measure_start = temp_go;
	// [RL11] warnings refreshed per measurement
	// [RL12] warnings only reported, nothing else
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			heat_low_r <= 1'b0;
			heat_high_r <= 1'b0;
		end else if (temp_go) begin
			heat_low_r <= heat_lo_s;
			heat_high_r <= heat_hi_s;
		end
	end
	// ----------------------------------------
	// status and access flags
	// ----------------------------------------
	logic [7:2] stat_r; // sticky status bits
	logic [1:0] key_fail_r; // wrong-key run length
	logic nvm_req, bad_key, set_cmd, set_reg, set_res, set_ok, set_lock;
	assign nvm_req = take && link.req_kind == REQ_NVM;
	assign bad_key = nvm_req && !stat_r[BIT_KEY_LOCKOUT] && !link.req_key_ok;
	// [RL17] unknown command or bad frame
	assign set_cmd = take && (link.req_kind == REQ_BAD || (link.req_kind == REQ_CMD && link.req_cmd != CMD_TEMP_ONE &&
		link.req_cmd != CMD_TEMP_ALL && link.req_cmd != CMD_CLEAR_FAULTS));
	// [RL19] unknown read address or write to any but the status register, link keeps running
	assign set_reg = (rd && !known_addr) || (take && link.req_kind == REQ_WRITE && link.req_addr != STATUS_AND_CLEAR_ADDR);
	// [RL20] restricted nonvolatile register
	assign set_res = nvm_req && !stat_r[BIT_KEY_LOCKOUT] && link.req_key_ok && link.req_restricted;
	// [RL21] completed nonvolatile access
	assign set_ok = nvm_req && !stat_r[BIT_KEY_LOCKOUT] && link.req_key_ok && !link.req_restricted;
	// [RL18] third wrong key in a row
	assign set_lock = bad_key && key_fail_r == KEY_TRIES_MAX - 2'd1;
	// count consecutive wrong keys, a good key restarts the run
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			key_fail_r <= '0;
		end else if (bad_key && key_fail_r != KEY_TRIES_MAX) begin
			key_fail_r <= key_fail_r + 2'd1;
		end else if (nvm_req && link.req_key_ok) begin
			key_fail_r <= '0;
		end
	end
	// write-one clears; a set in the same cycle wins
	// [RL16] reset indicator written by host only
	// [RL24] every flag sticky but the reset indicator, which holds the last host write
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			stat_r <= STATUS_RESET_VAL[7:2];
		end else begin
			if (wr_status) begin
				stat_r[BIT_RESET_IND] <= wd[BIT_RESET_IND];
			end
			stat_r[BIT_ILLEGAL_CMD] <= set_cmd | (stat_r[BIT_ILLEGAL_CMD] & ~(wr_status & wd[BIT_ILLEGAL_CMD]));
			// lockout has no write-one clear: only power-on frees it
			stat_r[BIT_KEY_LOCKOUT] <= set_lock | stat_r[BIT_KEY_LOCKOUT];
			stat_r[BIT_BAD_REG] <= set_reg | (stat_r[BIT_BAD_REG] & ~(wr_status & wd[BIT_BAD_REG]));
			stat_r[BIT_RESTRICTED] <= set_res | (stat_r[BIT_RESTRICTED] & ~(wr_status & wd[BIT_RESTRICTED]));
			stat_r[BIT_NVM_SUCCESS] <= set_ok | (stat_r[BIT_NVM_SUCCESS] & ~(wr_status & wd[BIT_NVM_SUCCESS]));
		end
	end
	// ----------------------------------------
	// read answers
	// ----------------------------------------
	logic [7:0] rdata;
	// [RL22] clear bits always read zero
	// [RL2] code register part of the answer set
	always_comb begin
		rdata = 8'h00;
		case (link.req_addr)
			STATUS_AND_CLEAR_ADDR: rdata = {stat_r, 2'b00};
			OPEN_FAULT_LO_ADDR: rdata = open_fault_r[7:0];
			OPEN_FAULT_HI_ADDR: rdata = {4'h0, open_fault_r[11:8]};
			SHORT_FAULT_LO_ADDR: rdata = short_fault_r[7:0];
			SHORT_FAULT_HI_ADDR: rdata = {4'h0, short_fault_r[11:8]};
			BOARD_CODE_ADDR: rdata = {heat_low_r, heat_high_r, health_s, fallback_s, code_r, code_fault_r};
			default: rdata = 8'h00;
		endcase
	end
	// registered answer one cycle after the read
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			link.rsp_valid <= 1'b0;
			link.rsp_data <= 8'h00;
		end else begin
			link.rsp_valid <= rd && known_addr;
			link.rsp_data <= (rd && known_addr) ? rdata : 8'h00;
		end
	end
endmodule : diag_device
`default_nettype wire

// ### design/diag_pkg.sv
package diag_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] STATUS_AND_CLEAR_ADDR = 8'h34;
	localparam logic [7:0] OPEN_FAULT_LO_ADDR = 8'h35;
	localparam logic [7:0] OPEN_FAULT_HI_ADDR = 8'h36;
	localparam logic [7:0] SHORT_FAULT_LO_ADDR = 8'h37;
	localparam logic [7:0] SHORT_FAULT_HI_ADDR = 8'h38;
	localparam logic [7:0] BOARD_CODE_ADDR = 8'h3A;
	localparam logic [7:0] STATUS_RESET_VAL = 8'h00;
	// ----------------------------------------
	// status_and_clear field positions
	// ----------------------------------------
	localparam int BIT_RESET_IND = 7;
	localparam int BIT_ILLEGAL_CMD = 6;
	localparam int BIT_KEY_LOCKOUT = 5;
	localparam int BIT_BAD_REG = 4;
	localparam int BIT_RESTRICTED = 3;
	localparam int BIT_NVM_SUCCESS = 2;
	localparam int BIT_CLEAR_OPEN = 1;
	localparam int BIT_CLEAR_SHORT = 0;
	// board_code_and_warnings field positions
	localparam int BIT_HEAT_LOW = 7;
	localparam int BIT_HEAT_HIGH = 6;
	localparam int BIT_HEALTH = 5;
	localparam int BIT_FALLBACK = 4;
	localparam int BIT_CODE_LSB = 1;
	localparam int BIT_RESISTOR_FAULT = 0;
	// ----------------------------------------
	// sizes and commands
	// ----------------------------------------
	localparam int CHANNELS = 12;
	localparam int CODE_W = 3;
	localparam logic [5:0] CMD_TEMP_ONE = 6'd13;
	localparam logic [5:0] CMD_TEMP_ALL = 6'd46;
	localparam logic [5:0] CMD_CLEAR_FAULTS = 6'd39;
	localparam logic [1:0] KEY_TRIES_MAX = 2'd3;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int BLANK_SHORT_US = 16;
	localparam int BLANK_LONG_US = 32;
	localparam int BLANK_SHORT_CYC = BLANK_SHORT_US * CLK_MHZ;
	localparam int BLANK_LONG_CYC = BLANK_LONG_US * CLK_MHZ;
	localparam int BLANK_W = 11;
	// bus request kinds
	typedef enum logic [2:0] {
		REQ_READ,
		REQ_WRITE,
		REQ_CMD,
		REQ_NVM,
		REQ_BAD
	} req_kind_t;
endpackage : diag_pkg

// ### design/diag_link_if.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// message-level link standing in for decoded bus frames
// ----------------------------------------
interface diag_link_if;
	import diag_pkg::*;
	logic req_valid; // one-cycle request pulse
	diag_pkg::req_kind_t req_kind; // what the frame asks
	logic req_bcast; // broadcast frame id
	logic [7:0] req_addr; // register address
	logic [7:0] req_wdata; // write data
	logic [5:0] req_cmd; // command code
	logic req_key_ok; // nonvolatile key matched
	logic req_restricted; // nonvolatile register is restricted
	logic rsp_valid; // read answer pulse
	logic [7:0] rsp_data; // read answer data
	logic link_ready; // device accepts frames
	modport device (input req_valid, req_kind, req_bcast, req_addr, req_wdata, req_cmd, req_key_ok,
		req_restricted, output rsp_valid, rsp_data, link_ready);
	modport host (output req_valid, req_kind, req_bcast, req_addr, req_wdata, req_cmd, req_key_ok,
		req_restricted, input rsp_valid, rsp_data, link_ready);
endinterface : diag_link_if
`default_nettype wire

// ### design/diag_host.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// host end: turns user requests into link frames
// ----------------------------------------
module diag_host (
	input wire logic clk_sys,
	input wire logic resetn,
	diag_link_if.host link,
	input wire logic user_valid,
	input wire diag_pkg::req_kind_t user_kind,
	input wire logic user_bcast,
	input wire logic [7:0] user_addr,
	input wire logic [7:0] user_wdata,
	input wire logic [5:0] user_cmd,
	input wire logic user_key_ok,
	input wire logic user_restricted,
	output logic user_ready,
	output logic user_rvalid,
	output logic [7:0] user_rdata
);
	import diag_pkg::*;

	// one frame per cycle while the device listens; held off otherwise
	assign user_ready = link.link_ready;

	// frame registers
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			link.req_valid <= 1'b0;
			link.req_kind <= REQ_READ;
			link.req_bcast <= 1'b0;
			link.req_addr <= 8'h00;
			link.req_wdata <= 8'h00;
			link.req_cmd <= 6'h00;
			link.req_key_ok <= 1'b0;
			link.req_restricted <= 1'b0;
		end else begin
			link.req_valid <= user_valid && link.link_ready;
			if (user_valid && link.link_ready) begin
				link.req_kind <= user_kind;
				link.req_bcast <= user_bcast;
				link.req_addr <= user_addr;
				link.req_wdata <= user_wdata;
				link.req_cmd <= user_cmd;
				link.req_key_ok <= user_key_ok;
				link.req_restricted <= user_restricted;
			end
		end
	end

	// answers pass back registered
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			user_rvalid <= 1'b0;
			user_rdata <= 8'h00;
		end else begin
			user_rvalid <= link.rsp_valid;
			user_rdata <= link.rsp_data;
		end
	end
endmodule : diag_host
`default_nettype wire

// ### tb/diag_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// link checker between host and device ends
// ----------------------------------------
module diag_assertions
	import diag_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic req_valid,
	input wire diag_pkg::req_kind_t req_kind,
	input wire logic [7:0] req_addr,
	input wire logic [7:0] req_wdata,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic link_ready
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	// requests the device takes; refused ones never count
	wire logic rd = req_valid && req_kind == REQ_READ && link_ready;
	wire logic wr = req_valid && req_kind == REQ_WRITE && link_ready;
	// mapped read addresses; the slot at 39h has no register here
	wire logic hit = req_addr >= 8'h34 && req_addr <= 8'h3A && req_addr != 8'h39;
	wire logic rd34 = rd && req_addr == STATUS_AND_CLEAR_ADDR;
	wire logic wr34 = wr && req_addr == STATUS_AND_CLEAR_ADDR;
	a_read_answer: assert property (rd && hit |=> rsp_valid)
		else $error("mapped read got no answer");
	a_bad_silent: assert property (rd && !hit |=> !rsp_valid)
		else $error("unmapped read was answered");
	a_uv_refused: assert property (req_valid && !link_ready |=> !rsp_valid)
		else $error("request answered while link refused");
	a_answer_cause: assert property (rsp_valid |-> $past(rd))
		else $error("answer without a read");
	a_idle_zero: assert property (!rsp_valid |-> rsp_data == 8'h00)
		else $error("answer data not zero when idle");
	a_clear_bits_zero: assert property (rd34 |=> rsp_data[1:0] == 2'b00)
		else $error("clear bits did not read zero");
	a_bad_reg_flag: assert property (wr && !wr34 ##1 rd34 |=> rsp_data[BIT_BAD_REG])
		else $error("bad register flag not set");
	a_bad_cmd_flag: assert property (req_valid && req_kind == REQ_BAD && link_ready ##1 rd34
		|=> rsp_data[BIT_ILLEGAL_CMD])
		else $error("illegal command flag not set");
	a_reset_ind_rw: assert property (wr34 ##1 rd34
		|=> rsp_data[BIT_RESET_IND] == $past(req_wdata[BIT_RESET_IND], 2))
		else $error("reset indicator did not keep written value");
	// main traffic seen
	c_status_read: cover property (rd34 ##1 rsp_valid);
	c_uv_refusal: cover property (req_valid && !link_ready);
	c_bad_read: cover property (rd && !hit);
endmodule : diag_assertions
`default_nettype wire

// ### tb/led_fault_diag_status_bench.sv
`timescale 1ns/100ps
`default_nettype none
module led_fault_diag_status_bench;
	import diag_pkg::*;
	localparam int DLY = 2; // drive offset after the rising edge
	localparam logic [7:0] SA = STATUS_AND_CLEAR_ADDR;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	// user side of the host end
	logic user_valid = 1'b0, user_bcast = 1'b0, user_key_ok = 1'b0, user_restricted = 1'b0;
	req_kind_t user_kind = REQ_READ;
	logic [7:0] user_addr = 8'h00, user_wdata = 8'h00, user_rdata;
	logic [5:0] user_cmd = 6'd0;
	logic user_ready, user_rvalid, open_thresh_high, all_switches_open, temp_measure_start;
	// far side of the device end
	logic [CODE_W-1:0] board_code_adc = '0;
	logic board_resistor_fault_in = 1'b0, heat_low_cmp = 1'b0, heat_high_cmp = 1'b0;
	logic chip_health_in = 1'b1, fallback_mode_in = 1'b0, undervoltage = 1'b0;
	logic long_blank_sel = 1'b0, open_thresh_high_sel = 1'b0;
	logic [CHANNELS-1:0] open_cmp = '0, short_cmp = '0, switch_high_ohmic = '0, bypass_close, m;
	// bench model: status and code registers as the rules give them
	int err_total = 0, total_checks = 0, starts = 0;
	logic [7:0] st_m = 8'h00, id_m;
	always #12.5 clk_sys = ~clk_sys;
	diag_link_if link();
	diag_device i_diag_device(.clk_sys(clk_sys), .resetn(resetn), .link(link), .board_code_adc(board_code_adc),
		.board_resistor_fault_in(board_resistor_fault_in), .open_cmp(open_cmp), .short_cmp(short_cmp),
		.switch_high_ohmic(switch_high_ohmic), .heat_low_cmp(heat_low_cmp), .heat_high_cmp(heat_high_cmp),
		.chip_health_in(chip_health_in), .fallback_mode_in(fallback_mode_in), .undervoltage(undervoltage),
		.long_blank_sel(long_blank_sel), .open_thresh_high_sel(open_thresh_high_sel),
		.open_thresh_high(open_thresh_high), .bypass_close(bypass_close), .all_switches_open(all_switches_open),
		.temp_measure_start(temp_measure_start));
	diag_host i_diag_host(.clk_sys(clk_sys), .resetn(resetn), .link(link), .user_valid(user_valid),
		.user_kind(user_kind), .user_bcast(user_bcast), .user_addr(user_addr), .user_wdata(user_wdata),
		.user_cmd(user_cmd), .user_key_ok(user_key_ok), .user_restricted(user_restricted),
		.user_ready(user_ready), .user_rvalid(user_rvalid), .user_rdata(user_rdata));
	diag_assertions i_diag_assertions(.clk_sys(clk_sys), .resetn(resetn), .req_valid(link.req_valid),
		.req_kind(link.req_kind), .req_addr(link.req_addr), .req_wdata(link.req_wdata),
		.rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data), .link_ready(link.link_ready));
	// the start pulse is combinational, so count it where it settles
	always @(posedge clk_sys) begin
		if (temp_measure_start === 1'b1) starts++;
	end
	task automatic chk(input string nm, input logic [11:0] got, input logic [11:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		#DLY;
	endtask : wt
	// one request cycle; valid is left high so calls may run back to back
	task automatic op(input req_kind_t k, input logic [7:0] a, input logic [7:0] d);
		user_kind = k;
		user_addr = a;
		user_wdata = d;
		user_valid = 1'b1;
		wt(1);
	endtask : op
	// read and compare; none means the device must stay silent
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input bit none);
		int n;
		n = 0;
		op(REQ_READ, a, 8'h00);
		user_valid = 1'b0;
		while (user_rvalid !== 1'b1 && n < 6) begin
			wt(1);
			n++;
		end
		chk("answer", 12'(user_rvalid), 12'(!none));
		if (!none) chk($sformatf("reg %h", a), 12'(user_rdata), 12'(e));
	endtask : rd
	// short flag must wait out the blanking count, then stick until cleared
	task automatic blank(input logic sel, input int lo);
		long_blank_sel = sel;
		switch_high_ohmic = '0;
		wt(4);
		short_cmp = m;
		switch_high_ohmic = m;
		wt(lo - 40);
		rd(SHORT_FAULT_LO_ADDR, 8'h00, 0);
		wt(80);
		rd(SHORT_FAULT_LO_ADDR, m[7:0], 0);
		rd(SHORT_FAULT_HI_ADDR, {4'h0, m[11:8]}, 0);
		chk("bypass", bypass_close, '0);
		short_cmp = '0;
		wt(4);
		rd(SHORT_FAULT_LO_ADDR, m[7:0], 0);
		user_bcast = 1'b1;
		op(REQ_WRITE, SA, st_m | 8'h01);
		user_bcast = 1'b0;
		rd(SHORT_FAULT_LO_ADDR, 8'h00, 0);
		$display("test blank %0d finished", lo);
	endtask : blank
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results
	// watchdog: the tests need some 3500 cycles
	initial begin
		#500000;
		err_total++;
		results();
	end
	initial begin
		void'($urandom(32'h76A9));
		board_code_adc = CODE_W'($urandom);
		board_resistor_fault_in = 1'($urandom);
		id_m = {4'b0010, board_code_adc, board_resistor_fault_in};
		m = CHANNELS'($urandom) | 12'h001;
		wt(20);
		resetn = 1'b1;
		wt(4);
		chk("thresh", 12'(open_thresh_high), 12'h000);
		rd(SA, st_m, 0);
		rd(BOARD_CODE_ADDR, id_m, 0);
		board_code_adc = ~board_code_adc;
		wt(4);
		rd(BOARD_CODE_ADDR, id_m, 0);
		$display("test startup finished");
		// status flags, each request back to back with its read
		st_m = 8'h80;
		op(REQ_WRITE, SA, st_m);
		rd(SA, st_m, 0);
		op(REQ_WRITE, 8'h35 + 8'($urandom % 200), 8'h00);
		rd(SA, 8'h90, 0);
		rd(8'h39, 8'h00, 1);
		op(REQ_BAD, 8'h00, 8'h00);
		rd(SA, 8'hD0, 0);
		op(REQ_WRITE, SA, 8'hD0);
		user_cmd = 6'd20;
		op(REQ_CMD, 8'h00, 8'h00);
		rd(SA, 8'hC0, 0);
		op(REQ_WRITE, SA, 8'hC0);
		rd(SA, st_m, 0);
		$display("test status finished");
		// open faults in fallback mode
		fallback_mode_in = 1'b1;
		id_m[BIT_FALLBACK] = 1'b1;
		switch_high_ohmic = m;
		open_cmp = m;
		wt(4);
		chk("bypass", bypass_close, m);
		open_cmp = '0;
		wt(4);
		rd(OPEN_FAULT_LO_ADDR, m[7:0], 0);
		rd(OPEN_FAULT_HI_ADDR, {4'h0, m[11:8]}, 0);
		rd(BOARD_CODE_ADDR, id_m, 0);
		op(REQ_WRITE, SA, 8'h82);
		rd(SA, st_m, 0);
		chk("bypass", bypass_close, '0);
		blank(1'b0, BLANK_SHORT_CYC);
		blank(1'b1, BLANK_LONG_CYC);
		// clear-all command
		short_cmp = m;
		open_cmp = m;
		wt(1300);
		chk("bypass", bypass_close, m);
		short_cmp = '0;
		open_cmp = '0;
		// let the comparators settle through the synchronisers, or the set beats the clear
		wt(4);
		user_cmd = CMD_CLEAR_FAULTS;
		op(REQ_CMD, 8'h00, 8'h00);
		rd(OPEN_FAULT_LO_ADDR, 8'h00, 0);
		rd(SHORT_FAULT_LO_ADDR, 8'h00, 0);
		$display("test faults finished");
		// heat warnings move only on command
		heat_low_cmp = 1'b1;
		wt(4);
		rd(BOARD_CODE_ADDR, id_m, 0);
		user_cmd = CMD_TEMP_ONE;
		op(REQ_CMD, 8'h00, 8'h00);
		id_m[BIT_HEAT_LOW] = 1'b1;
		rd(BOARD_CODE_ADDR, id_m, 0);
		heat_high_cmp = 1'b1;
		user_cmd = CMD_TEMP_ALL;
		user_bcast = 1'b1;
		wt(4);
		op(REQ_CMD, 8'h00, 8'h00);
		user_bcast = 1'b0;
		id_m[BIT_HEAT_HIGH] = 1'b1;
		rd(BOARD_CODE_ADDR, id_m, 0);
		chk("switches", 12'(all_switches_open), 12'h000);
		chk("starts", 12'(starts), 12'h002);
		rd(SA, st_m, 0);
		$display("test heat finished");
		// nonvolatile access flags and key lockout
		user_key_ok = 1'b1;
		op(REQ_NVM, 8'h00, 8'h00);
		rd(SA, 8'h84, 0);
		user_restricted = 1'b1;
		op(REQ_NVM, 8'h00, 8'h00);
		rd(SA, 8'h8C, 0);
		user_restricted = 1'b0;
		user_key_ok = 1'b0;
		op(REQ_WRITE, SA, 8'h8C);
		op(REQ_NVM, 8'h00, 8'h00);
		op(REQ_NVM, 8'h00, 8'h00);
		rd(SA, st_m, 0);
		op(REQ_NVM, 8'h00, 8'h00);
		st_m = 8'hA0;
		rd(SA, st_m, 0);
		user_key_ok = 1'b1;
		op(REQ_NVM, 8'h00, 8'h00);
		op(REQ_WRITE, SA, 8'hFF);
		rd(SA, st_m, 0);
		$display("test nvm finished");
		// undervoltage refuses the link and keeps state
		undervoltage = 1'b1;
		// a frame launched just as the supply drops must still be refused
		wt(1);
		rd(SA, 8'h00, 1);
		chk("ready", 12'(user_ready), 12'h000);
		chk("switches", 12'(all_switches_open), 12'h001);
		rd(SA, 8'h00, 1);
		undervoltage = 1'b0;
		open_thresh_high_sel = 1'b1;
		wt(4);
		rd(SA, st_m, 0);
		chk("thresh", 12'(open_thresh_high), 12'h001);
		$display("test supply finished");
		results();
	end
endmodule : led_fault_diag_status_bench
`default_nettype wire
